// File: logic/iam_mapper.sv
// Indirect address mapper: resolves pointer accesses onto data memory or program flash.
`timescale 1ns/1ps
// Behaviour
// - The indirect port stores nothing and every access goes to the location the selected pointer holds.
// - A pointer aimed at either indirect port location reads zero and drops the write.
// - Each pointer is its high byte concatenated with its low byte into a 16-bit address.
// - Pointers 0x000 to 0xFFF map one to one onto absolute data addresses.
// - Pointers 0x2000 to 0x29AF map onto the 80-byte banked RAM blocks in bank order.
// - Linear reads that land on unimplemented memory return 0x00.
// - Stepping past the last RAM byte of a bank lands on the first RAM byte of the next bank.
// - The 16 common bytes never appear in the linear window.
// - With the pointer top bit set, the lower 15 bits address program flash.
// - A flash read returns only the low eight bits of the word.
// - Writes aimed at flash never modify program memory.
// - A flash read takes one extra cycle beyond a data access.
module iam_mapper import iam_pkg::*; #(
	parameter int LIN_BANKS = LIN_BANKS_DEF
) (
	input wire logic CLK, // core clock
	input wire logic ARST_N, // async reset, active low
	input wire iam_req_t REQ, // indirect port access from the core
	output logic REQ_READY, // unit can take an access
	input wire logic [7:0] PTR0_HIGH, // pointer 0 high byte
	input wire logic [7:0] PTR0_LOW, // pointer 0 low byte
	input wire logic [7:0] PTR1_HIGH, // pointer 1 high byte
	input wire logic [7:0] PTR1_LOW, // pointer 1 low byte
	output iam_mem_t MEM, // data memory access
	input wire logic [7:0] MEM_RDATA, // data memory read data, same cycle as strobe
	output iam_flash_t FLASH, // program flash read
	input wire logic [13:0] FLASH_RDATA, // flash word, valid cycle after strobe
	output logic DONE, // access complete pulse
	output logic [7:0] RDATA // read result
);

	// ********************************************************
	// Address decode
	// ********************************************************
	iam_state_t cur;
	iam_state_t next_cur;
	logic [PTR_W-1:0] ptr0;
	logic [PTR_W-1:0] ptr1;
	logic [PTR_W-1:0] ptr;
	logic take;
	logic in_trad;
	logic in_lin;
	logic in_flash;
	logic self_ref;
	logic [11:0] lin_ofs;
	logic [11:0] lin_bank;
	logic [11:0] lin_byte;
	logic lin_impl;
	logic [DADDR_W-1:0] lin_addr;

	assign ptr0 = {PTR0_HIGH, PTR0_LOW};
	assign ptr1 = {PTR1_HIGH, PTR1_LOW};
	// The chosen pointer is steered ahead of decode, so both pointers share one decoder.
	assign ptr = REQ.sel ? ptr1 : ptr0;
	assign take = REQ.valid && REQ_READY;
	assign in_flash = ptr[FLASH_BIT];
	assign in_trad = !in_flash && (ptr <= TRAD_LAST);
	assign in_lin = (ptr >= LIN_FIRST) && (ptr <= LIN_LAST);
	// Every bank carries the two indirect port images at its lowest offsets, so only the bank offset matters.
	assign self_ref = in_trad && (ptr[OFS_W-1:0] < SELF_LIMIT);

	// Division by a constant keeps bank stepping gap free; the byte index lin_byte is always below 80.
	assign lin_ofs = ptr[DADDR_W-1:0] - LIN_FIRST[DADDR_W-1:0];
	assign lin_bank = lin_ofs / LIN_BLOCK;
	assign lin_byte = 12'(lin_ofs - 12'(lin_bank * LIN_BLOCK));
	// Banks beyond LIN_BANKS are not fitted; their linear addresses answer zero.
	assign lin_impl = lin_bank < 12'(LIN_BANKS);
	assign lin_addr = {lin_bank[BANK_W-1:0], 7'(GPR_BASE + lin_byte[OFS_W-1:0])};

	assign REQ_READY = (cur.st == IAM_IDLE);
	assign MEM = cur.mem;
	assign FLASH = cur.fl;
	assign DONE = cur.done;
	assign RDATA = cur.rdata;

	// ********************************************************
	// Sequencer
	// ********************************************************
	// Strobes and done are pulses: they default low and are raised for exactly one cycle.
	always_comb begin
		next_cur = cur;
		next_cur.mem.stb = 1'b0;
		next_cur.fl.stb = 1'b0;
		next_cur.done = 1'b0;
		case (cur.st)
			IAM_IDLE: begin
				if (take) begin
					next_cur.mem.we = REQ.write;
					next_cur.mem.wdata = REQ.wdata;
					if (in_flash) begin
						if (REQ.write) begin
							// Flash is read-only on this path, so the write is answered like a hole.
							next_cur.st = IAM_ZERO;
						end else begin
							next_cur.fl.stb = 1'b1;
							next_cur.fl.addr = ptr[FADDR_W-1:0];
							next_cur.st = IAM_FEXT;
						end
					end else if (in_trad && !self_ref) begin
						next_cur.mem.stb = 1'b1;
						next_cur.mem.addr = ptr[DADDR_W-1:0];
						next_cur.st = IAM_DCAP;
					end else if (in_lin && lin_impl) begin
						next_cur.mem.stb = 1'b1;
						next_cur.mem.addr = lin_addr;
						next_cur.st = IAM_DCAP;
					end else begin
						next_cur.st = IAM_ZERO;
					end
				end
			end
			IAM_DCAP: begin
				next_cur.done = 1'b1;
				next_cur.rdata = cur.mem.we ? ZERO_BYTE : MEM_RDATA;
				next_cur.st = IAM_IDLE;
			end
			IAM_FEXT: begin
				// The flash needs this cycle to present the word.
				next_cur.st = IAM_FCAP;
			end
			IAM_FCAP: begin
				next_cur.done = 1'b1;
				next_cur.rdata = FLASH_RDATA[7:0];
				next_cur.st = IAM_IDLE;
			end
			IAM_ZERO: begin
				next_cur.done = 1'b1;
				next_cur.rdata = ZERO_BYTE;
				next_cur.st = IAM_IDLE;
			end
			default: begin
				next_cur.st = IAM_IDLE;
			end
		endcase
	end

	// One register carries state, strobes and result, so every data output leaves a flip-flop.
	// The price is one cycle of latency on every access, which the core already budgets for.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	sequence s_take_flash_read;
		take && in_flash && !REQ.write;
	endsequence

	sequence s_flash_reply;
		##1 FLASH.stb && !DONE ##1 !DONE ##1 DONE;
	endsequence

	sequence s_data_reply;
		##1 MEM.stb && !DONE ##1 DONE;
	endsequence

	AST_SELF_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && !in_flash && self_ref |-> ##1 !MEM.stb ##1 DONE && RDATA == ZERO_BYTE)
		else $error("self reference did not read zero");

	AST_TRAD_ADDR: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_trad && !self_ref |-> ##1 MEM.stb && MEM.addr == $past(ptr[DADDR_W-1:0])
		&& MEM.we == $past(REQ.write))
		else $error("traditional access went to wrong address");

	AST_PTR_JOIN: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_trad && !self_ref && REQ.sel |-> ##1 MEM.addr == $past({PTR1_HIGH[3:0], PTR1_LOW}))
		else $error("pointer bytes not joined");

	AST_LIN_MAP: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin && lin_impl |-> ##1 MEM.stb
		&& 12'({7'h00, MEM.addr[11:7]} * LIN_BLOCK) + 12'(MEM.addr[6:0] - GPR_BASE)
		== $past(ptr[11:0]))
		else $error("linear window mapped wrongly");

	AST_LIN_GPR_ONLY: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin |-> ##1 !MEM.stb || (MEM.addr[6:0] >= GPR_BASE && MEM.addr[6:0] < 7'h70))
		else $error("linear window hit common or special bytes");

	AST_LIN_UNIMPL: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin && !lin_impl |-> ##1 !MEM.stb ##1 DONE && RDATA == ZERO_BYTE)
		else $error("unimplemented linear read not zero");

	AST_FLASH_ADDR: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_take_flash_read |-> ##1 FLASH.stb && FLASH.addr == $past(ptr[FADDR_W-1:0]) && !MEM.stb)
		else $error("flash address wrong");

	AST_FLASH_EXTRA: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_take_flash_read |-> s_flash_reply)
		else $error("flash read timing wrong");

	AST_DATA_TIME: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_trad && !self_ref |-> s_data_reply)
		else $error("data access timing wrong");

	AST_FLASH_LOW: assert property (@(posedge CLK) disable iff (!ARST_N)
		cur.st == IAM_FCAP |-> ##1 DONE && RDATA == $past(FLASH_RDATA[7:0]))
		else $error("flash byte not low eight bits");

	AST_FLASH_NOWRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_flash && REQ.write |-> ##1 !MEM.stb && !FLASH.stb ##1 DONE)
		else $error("flash write was not discarded");

	AST_HOLE: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && !in_flash && !in_trad && !in_lin |-> ##1 !MEM.stb ##1 DONE && RDATA == ZERO_BYTE)
		else $error("hole access not zero");

	AST_NO_STORE: assert property (@(posedge CLK) disable iff (!ARST_N)
		MEM.stb |-> $past(take))
		else $error("memory strobe without an access");

	// ********************************************************
	// Handshake and result checks
	// ********************************************************
	// These watch the answers as the core sees them, so a slip in the sequencer shows
	// up even where the decode checks above stay quiet.
	sequence s_take_data_read;
		take && !REQ.write && !in_flash && ((in_trad && !self_ref) || (in_lin && lin_impl));
	endsequence

	sequence s_take_data_write;
		take && REQ.write && !in_flash && ((in_trad && !self_ref) || (in_lin && lin_impl));
	endsequence

	sequence s_zero_reply;
		##1 !MEM.stb && !FLASH.stb && !DONE ##1 DONE && RDATA == ZERO_BYTE;
	endsequence

	AST_PTR0_JOIN: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_trad && !self_ref && !REQ.sel |-> ##1 MEM.addr == $past({PTR0_HIGH[3:0], PTR0_LOW}))
		else $error("pointer 0 bytes not joined");

	AST_FLASH_JOIN: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_take_flash_read |-> ##1 FLASH.addr
		== $past(REQ.sel ? {PTR1_HIGH[6:0], PTR1_LOW} : {PTR0_HIGH[6:0], PTR0_LOW}))
		else $error("flash pointer bytes not joined");

	AST_DATA_READ: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_take_data_read |-> ##1 MEM.stb && !MEM.we ##1 DONE && RDATA == $past(MEM_RDATA))
		else $error("data read result not passed through");

	AST_WRITE_PASS: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_take_data_write |-> ##1 MEM.stb && MEM.we && MEM.wdata == $past(REQ.wdata)
		##1 DONE && RDATA == ZERO_BYTE)
		else $error("data write not passed through");

	AST_SELF_WRITE_DROP: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && self_ref && REQ.write |-> s_zero_reply)
		else $error("self reference write was not dropped");

	AST_FLASH_WRITE_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_flash && REQ.write |-> s_zero_reply)
		else $error("flash write touched a bus");

	AST_LIN_WRITE_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin && !lin_impl && REQ.write |-> s_zero_reply)
		else $error("unimplemented linear write touched memory");

	AST_SAFE_OFFSET: assert property (@(posedge CLK) disable iff (!ARST_N)
		MEM.stb |-> MEM.addr[OFS_W-1:0] >= SELF_LIMIT)
		else $error("memory strobe aimed at an indirect port image");

	AST_ONE_TARGET: assert property (@(posedge CLK) disable iff (!ARST_N)
		MEM.stb |-> !FLASH.stb)
		else $error("data and flash strobed together");

	AST_MEM_PULSE: assert property (@(posedge CLK) disable iff (!ARST_N)
		MEM.stb |=> !MEM.stb)
		else $error("memory strobe longer than one cycle");

	AST_FLASH_PULSE: assert property (@(posedge CLK) disable iff (!ARST_N)
		FLASH.stb |=> !FLASH.stb && !DONE)
		else $error("flash strobe not followed by the wait cycle");

	AST_DONE_PULSE: assert property (@(posedge CLK) disable iff (!ARST_N)
		DONE |=> !DONE)
		else $error("done longer than one cycle");

	AST_TAKE_BUSY: assert property (@(posedge CLK) disable iff (!ARST_N)
		take |=> !REQ_READY)
		else $error("unit ready in the cycle after an access was taken");

	AST_DONE_CAUSE: assert property (@(posedge CLK) disable iff (!ARST_N)
		DONE |-> $past(!REQ_READY))
		else $error("done without an access in progress");

	AST_RDATA_HOLD: assert property (@(posedge CLK) disable iff (!ARST_N)
		!DONE |-> $stable(RDATA))
		else $error("result changed without done");

	AST_LIN_STEP: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin && lin_impl |-> ##1 (MEM.addr[OFS_W-1:0] == GPR_BASE)
		== (($past(ptr[DADDR_W-1:0]) % LIN_BLOCK) == 12'h000))
		else $error("linear bank step left a gap");

	AST_LIN_BANKS: assert property (@(posedge CLK) disable iff (!ARST_N)
		take && in_lin && lin_impl |-> ##1 {7'h00, MEM.addr[DADDR_W-1:OFS_W]} < 12'(LIN_BANKS))
		else $error("linear access beyond the fitted banks");

endmodule // iam_mapper

// File: logic/iam_pkg.sv
// Constants, carrier structs and state encoding for the indirect address mapper.
package iam_pkg;

	// ********************************************************
	// Address map
	// ********************************************************
	localparam int PTR_W = 16;
	localparam int DADDR_W = 12;
	localparam int FADDR_W = 15;
	localparam int BANK_W = 5;
	localparam int OFS_W = 7;
	localparam int FLASH_BIT = 15;
	localparam logic [15:0] TRAD_LAST = 16'h0FFF;
	localparam logic [15:0] LIN_FIRST = 16'h2000;
	localparam logic [15:0] LIN_LAST = 16'h29AF;
	localparam logic [11:0] LIN_BLOCK = 12'h050;
	localparam logic [6:0] GPR_BASE = 7'h20;
	localparam logic [6:0] SELF_LIMIT = 7'h02;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int LIN_BANKS_DEF = 2;

	// ********************************************************
	// Carriers
	// ********************************************************
	typedef struct packed {
		logic valid;
		logic write;
		logic sel;
		logic [7:0] wdata;
	} iam_req_t;

	typedef struct packed {
		logic stb;
		logic we;
		logic [DADDR_W-1:0] addr;
		logic [7:0] wdata;
	} iam_mem_t;

	typedef struct packed {
		logic stb;
		logic [FADDR_W-1:0] addr;
	} iam_flash_t;

	typedef enum logic [2:0] {
		IAM_IDLE = 3'b000,
		IAM_DCAP = 3'b001,
		IAM_FEXT = 3'b010,
		IAM_FCAP = 3'b011,
		IAM_ZERO = 3'b100
	} iam_fsm_t;

	typedef struct packed {
		iam_fsm_t st;
		iam_mem_t mem;
		iam_flash_t fl;
		logic done;
		logic [7:0] rdata;
	} iam_state_t;

endpackage

// File: tb/iam_mem_model.sv
// Data memory and program flash model that answers the mapper.
`timescale 1ns/1ps
module iam_mem_model import iam_pkg::*; (
	input wire logic CLK, // core clock
	input wire iam_mem_t MEM, // data access from mapper
	output logic [7:0] MEM_RDATA, // read data in strobe cycle
	input wire iam_flash_t FLASH, // flash read from mapper
	output logic [13:0] FLASH_RDATA // flash word in cycle after strobe
);
	logic [7:0] mem [0:4095];
	logic fl_due = 1'b0;
	logic [14:0] fl_addr = 15'h0000;
	logic [13:0] fl_word;
	int wr_cnt = 0;
	// The bank bits are folded into the pattern so a wrong bank reads a different value.
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
	// Outside its valid cycle a bus shows the inverse, so a late or early sample is caught.
	assign MEM_RDATA = MEM.stb ? mem[MEM.addr] : ~mem[MEM.addr];
	assign fl_word = {fl_addr[13:8], ~fl_addr[7:0]};
	assign FLASH_RDATA = fl_due ? fl_word : ~fl_word;
	always @(posedge CLK) begin
		fl_due <= FLASH.stb;
		if (FLASH.stb) fl_addr <= FLASH.addr;
		if (MEM.stb && MEM.we) begin
			mem[MEM.addr] <= MEM.wdata;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule // iam_mem_model

// File: tb/iam_mapper_tb.sv
// Self-checking testbench for the indirect address mapper.
`timescale 1ns/1ps
module iam_mapper_tb import iam_pkg::*;;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	iam_req_t REQ = '0;
	logic REQ_READY, DONE;
	logic [7:0] PTR0_HIGH = 8'h00, PTR0_LOW = 8'h00, PTR1_HIGH = 8'h00, PTR1_LOW = 8'h00;
	logic [7:0] MEM_RDATA, RDATA;
	logic [13:0] FLASH_RDATA;
	iam_mem_t MEM;
	iam_flash_t FLASH;
	int num_errors = 0;
	int tests_run = 0;
	int w0;
	always #20 CLK = ~CLK;
	iam_mapper #(.LIN_BANKS(3)) dut (.CLK(CLK), .ARST_N(ARST_N), .REQ(REQ), .REQ_READY(REQ_READY),
		.PTR0_HIGH(PTR0_HIGH), .PTR0_LOW(PTR0_LOW), .PTR1_HIGH(PTR1_HIGH), .PTR1_LOW(PTR1_LOW),
		.MEM(MEM), .MEM_RDATA(MEM_RDATA), .FLASH(FLASH), .FLASH_RDATA(FLASH_RDATA), .DONE(DONE), .RDATA(RDATA));
	iam_mem_model model (.CLK(CLK), .MEM(MEM), .MEM_RDATA(MEM_RDATA), .FLASH(FLASH), .FLASH_RDATA(FLASH_RDATA));

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic [7:0] mv(input logic [7:0] a);
		return a ^ 8'h3C;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The unused pointer holds the inverse, so a wrong pointer choice shows up as wrong data.
	task automatic acc(input logic s, input logic [15:0] p, input logic w, input logic [7:0] wd,
		input logic [7:0] er, input int ec);
		int n;
		@(posedge CLK);
		#1;
		{PTR0_HIGH, PTR0_LOW} = s ? ~p : p;
		{PTR1_HIGH, PTR1_LOW} = s ? p : ~p;
		REQ = '{1'b1, w, s, wd};
		@(posedge CLK);
		#1;
		REQ.valid = 1'b0;
		chk("busy", 16'h0000, {15'h0000, REQ_READY});
		// The take edge counts as cycle one, so n ends on the reply cycle of the access.
		n = 1;
		while (n < 9 && DONE !== 1'b1) begin
			@(posedge CLK);
			#1;
			n++;
		end
		chk("cycles", 16'(ec), 16'(n));
		chk("rdata", {8'h00, er}, {8'h00, RDATA});
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic t_trad();
		acc(1'b0, 16'h0123, 1'b0, 8'h00, mv(8'h23) ^ 8'h01, 2);
		acc(1'b1, 16'h0FFF, 1'b0, 8'h00, mv(8'hFF) ^ 8'h0F, 2);
		acc(1'b1, 16'h00A5, 1'b1, 8'hC3, 8'h00, 2);
		acc(1'b0, 16'h00A5, 1'b0, 8'h00, 8'hC3, 2);
	endtask
	task automatic t_zero();
		w0 = model.wr_cnt;
		acc(1'b0, 16'h0080, 1'b0, 8'h00, 8'h00, 2);
		acc(1'b1, 16'h0101, 1'b0, 8'h00, 8'h00, 2);
		acc(1'b0, 16'h0000, 1'b1, 8'h77, 8'h00, 2);
		acc(1'b0, 16'h1000, 1'b1, 8'h77, 8'h00, 2);
		acc(1'b1, 16'h29B0, 1'b0, 8'h00, 8'h00, 2);
		acc(1'b1, 16'h8005, 1'b1, 8'h77, 8'h00, 2);
		acc(1'b0, 16'h2100, 1'b1, 8'h77, 8'h00, 2);
		chk("writes", 16'(w0), 16'(model.wr_cnt));
	endtask
	task automatic t_lin();
		acc(1'b0, 16'h2000, 1'b0, 8'h00, mv(8'h20), 2);
		acc(1'b1, 16'h204F, 1'b0, 8'h00, mv(8'h6F), 2);
		acc(1'b0, 16'h2050, 1'b0, 8'h00, mv(8'hA0), 2);
		acc(1'b1, 16'h20EF, 1'b0, 8'h00, mv(8'h6F) ^ 8'h01, 2);
		acc(1'b0, 16'h20F0, 1'b0, 8'h00, 8'h00, 2);
		acc(1'b1, 16'h29AF, 1'b0, 8'h00, 8'h00, 2);
		acc(1'b0, 16'h2051, 1'b1, 8'h5A, 8'h00, 2);
		acc(1'b1, 16'h00A1, 1'b0, 8'h00, 8'h5A, 2);
	endtask
	task automatic t_flash();
		acc(1'b0, 16'h8123, 1'b0, 8'h00, 8'hDC, 3);
		acc(1'b1, 16'hFF00, 1'b0, 8'h00, 8'hFF, 3);
		acc(1'b0, 16'h0123, 1'b0, 8'h00, mv(8'h23) ^ 8'h01, 2);
	endtask

	initial begin
		repeat (6) @(posedge CLK);
		#1;
		chk("ready_rst", 16'h0001, {15'h0000, REQ_READY});
		ARST_N = 1'b1;
		t_trad();
		t_zero();
		t_lin();
		t_flash();
		report_and_stop();
	end
	initial begin
		#100us;
		num_errors++;
		report_and_stop();
	end
endmodule // iam_mapper_tb
